// file: core/bvc_regs.sv
// Purpose: control and status registers of the brown-out detector and warning monitor
// Assumes: fuse inputs are stable when reset is released; unlock is a level from the key logic
// Notes:   fuse fields load on the first edge after reset release
`timescale 1ns/1ps
module bvc_regs
  import bvc_pkg::*;
#(
  parameter int FAST_CYC = FAST_DIV,
  parameter int SLOW_CYC = SLOW_DIV
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       prot_unlock,
  input  wire logic       fuse_sample_rate,
  input  wire logic [1:0] fuse_active_mode,
  input  wire logic [1:0] fuse_sleep_mode,
  input  wire logic [2:0] fuse_threshold,
  input  wire logic       deep_sleep,
  input  wire logic       supply_below_async,
  input  wire logic       detector_ready,
  output logic            detector_enable,
  output logic            detector_sampled,
  output logic            detector_rate,
  output logic      [2:0] detector_threshold,
  output logic      [1:0] monitor_margin,
  output logic            wake_hold,
  output logic            warning_irq_req,
  output logic            irq
);
  bvc_state_t       state;
  logic             sample_rate_sel;
  logic [1:0]       active_mode;
  logic [1:0]       sleep_mode;
  logic [2:0]       detect_threshold_code;
  logic [1:0]       warning_margin_select;
  logic [1:0]       crossing_trigger_select;
  logic             warning_irq_enable;
  logic             warning_irq_flag;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_en;
  logic [IRQ_N-1:0] irq_ev;
  logic [IRQ_N-1:0] irq_clr;
  logic             ready_q;
  logic [1:0]       eff_mode;
  logic             det_on;
  logic             det_smp;
  logic             det_run;
  logic             trig_hit;
  logic             arm_set;
  logic             flag_set;
  logic             flag_clr;
  logic             wr_mode;
  logic             wr_margin;
  logic             wr_monitor_interrupt_control;
  logic             wr_flags;
  logic             wr_irq_clr;
  logic             wr_irq_en;
  logic [7:0]       next_rdata;

  bvc_mon_if mon ();

  bvc_sampler #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_sampler (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .mon      (mon.smp)
  );

  // fuse values are caught one edge after release, never under the async reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= BVC_LOAD;
    end else begin
      case (state)
        BVC_LOAD: state <= BVC_RUN;
        BVC_RUN:  state <= BVC_RUN;
        default:  state <= BVC_LOAD;
      endcase
    end
  end

  // writes to read-only or unknown offsets decode to nothing and are dropped
  always_comb begin
    wr_mode    = 1'b0;
    wr_margin  = 1'b0;
    wr_monitor_interrupt_control = 1'b0;
    wr_flags   = 1'b0;
    wr_irq_clr = 1'b0;
    wr_irq_en  = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFF_MODE:    wr_mode    = 1'b1;
        OFF_MARGIN:  wr_margin  = 1'b1;
        OFF_MONITOR_INTERRUPT_CONTROL: wr_monitor_interrupt_control = 1'b1;
        OFF_FLAGS:   wr_flags   = 1'b1;
        OFF_IRQ_CLR: wr_irq_clr = 1'b1;
        OFF_IRQ_EN:  wr_irq_en  = 1'b1;
        default:     wr_mode    = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_rate_sel <= RATE_1KHZ;
    end else if (state == BVC_LOAD) begin
      sample_rate_sel <= fuse_sample_rate;
    end else if (wr_mode && prot_unlock) begin
      sample_rate_sel <= reg_wdata[POS_RATE];
    end
  end

  // no write path: software cannot change the awake mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_mode <= MODE_OFF;
    end else if (state == BVC_LOAD) begin
      active_mode <= fuse_active_mode;
    end
  end

  // unprotected writes are dropped silently, the field keeps its value
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_mode <= MODE_OFF;
    end else if (state == BVC_LOAD) begin
      sleep_mode <= fuse_sleep_mode;
    end else if (wr_mode && prot_unlock) begin
      sleep_mode <= reg_wdata[POS_SLEEP+:2];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      detect_threshold_code <= THR_CODE_ZERO;
    end else if (state == BVC_LOAD) begin
      detect_threshold_code <= fuse_threshold;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warning_margin_select <= RST_MARGIN;
    end else if (wr_margin) begin
      warning_margin_select <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crossing_trigger_select <= RST_TRIG;
    end else if (wr_monitor_interrupt_control) begin
      crossing_trigger_select <= reg_wdata[POS_TRIG+:2];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warning_irq_enable <= RST_IE;
    end else if (wr_monitor_interrupt_control) begin
      warning_irq_enable <= reg_wdata[POS_IE];
    end
  end

  // reserved sleep code 3 is treated as off
  always_comb begin
    eff_mode = deep_sleep ? sleep_mode : active_mode;
    det_on   = 1'b0;
    det_smp  = 1'b0;
    case (eff_mode)
      MODE_OFF: begin
        det_on = 1'b0;
      end
      MODE_ON: begin
        det_on = 1'b1;
      end
      MODE_SAMPLED: begin
        det_on  = 1'b1;
        det_smp = 1'b1;
      end
      MODE_ON_WAIT: begin
        det_on = !deep_sleep;
      end
      default: begin
        det_on = 1'b0;
      end
    endcase
  end

  // nothing runs before the fuse codes are in
  assign det_run = det_on && (state == BVC_RUN);

  // monitor runs only when the detector does, at the same cadence
  assign mon.mon_on      = det_run;
  assign mon.mon_sampled = det_smp;
  assign mon.rate_sel    = sample_rate_sel;
  assign mon.below_raw   = supply_below_async;

  always_comb begin
    trig_hit = 1'b0;
    case (crossing_trigger_select)
      TRIG_FROM_ABOVE: trig_hit = mon.cross_down;
      TRIG_FROM_BELOW: trig_hit = mon.cross_up;
      TRIG_EITHER:     trig_hit = mon.cross_down | mon.cross_up;
      default:         trig_hit = 1'b0;
    endcase
  end

  // enabling with the either-direction trigger raises the flag at once while the monitor runs
  assign arm_set  = wr_monitor_interrupt_control && reg_wdata[POS_IE] && !warning_irq_enable &&
                    (reg_wdata[POS_TRIG+:2] == TRIG_EITHER);
  assign flag_set = mon.mon_on && (trig_hit || arm_set);
  assign flag_clr = wr_flags && reg_wdata[POS_FLAG];

  // a crossing in the same cycle as a clear keeps the flag set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warning_irq_flag <= RST_FLAG;
    end else if (flag_set) begin
      warning_irq_flag <= 1'b1;
    end else if (flag_clr) begin
      warning_irq_flag <= 1'b0;
    end
  end

  assign warning_irq_req = warning_irq_enable & warning_irq_flag;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= detector_ready;
    end
  end

  assign irq_ev[IRQ_CROSS] = flag_set;
  assign irq_ev[IRQ_READY] = detector_ready & ~ready_q;
  assign irq_clr           = wr_irq_clr ? reg_wdata[IRQ_N-1:0] : '0;

  for (genvar i = 0; i < IRQ_N; i++) begin : g_stat
    // an event in the same cycle as its clear wins, so no event is lost
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        irq_stat[i] <= 1'b0;
      end else if (irq_ev[i]) begin
        irq_stat[i] <= 1'b1;
      end else if (irq_clr[i]) begin
        irq_stat[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en <= '0;
    end else if (wr_irq_en) begin
      irq_en <= reg_wdata[IRQ_N-1:0];
    end
  end

  // a level, so a late look by the interrupt controller loses nothing
  assign irq = |(irq_stat & irq_en);

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFF_MODE: begin
          next_rdata[POS_RATE]       = sample_rate_sel;
          next_rdata[POS_ACTIVE+:2]  = active_mode;
          next_rdata[POS_SLEEP+:2]   = sleep_mode;
        end
        OFF_LEVEL: begin
          next_rdata[2:0] = detect_threshold_code;
        end
        OFF_MARGIN: begin
          next_rdata[1:0] = warning_margin_select;
        end
        OFF_MONITOR_INTERRUPT_CONTROL: begin
          next_rdata[POS_TRIG+:2] = crossing_trigger_select;
          next_rdata[POS_IE]      = warning_irq_enable;
        end
        OFF_FLAGS: begin
          next_rdata[POS_FLAG] = warning_irq_flag;
        end
        OFF_STATUS: begin
          next_rdata[POS_BELOW] = mon.below;
        end
        OFF_IRQ_STAT: begin
          next_rdata[IRQ_N-1:0] = irq_stat;
        end
        OFF_IRQ_EN: begin
          next_rdata[IRQ_N-1:0] = irq_en;
        end
        // the write-only clear register and unmapped offsets read as zero
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  assign detector_enable    = det_run;
  assign detector_sampled   = det_smp;
  assign detector_rate      = sample_rate_sel;
  assign detector_threshold = detect_threshold_code;
  assign monitor_margin     = warning_margin_select;
  // awake wait mode holds wake-up until the analog side reports ready
  assign wake_hold = (active_mode == MODE_ON_WAIT) && !deep_sleep && !detector_ready;
endmodule // bvc_regs

// file: core/bvc_pkg.sv
// Purpose: shared constants and types of the brown-out detector register bank
// Assumes: 8-bit registers on a byte-wide register port
// Notes:   the two sample rates are derived from the core clock rate
package bvc_pkg;
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_LEVEL    = 8'h01;
  localparam logic [7:0] OFF_MARGIN   = 8'h08;
  localparam logic [7:0] OFF_MONITOR_INTERRUPT_CONTROL  = 8'h09;
  localparam logic [7:0] OFF_FLAGS    = 8'h0a;
  localparam logic [7:0] OFF_STATUS   = 8'h0b;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h0d;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h0e;

  localparam int POS_RATE   = 4;
  localparam int POS_ACTIVE = 2;
  localparam int POS_SLEEP  = 0;
  localparam int POS_TRIG   = 1;
  localparam int POS_IE     = 0;
  localparam int POS_FLAG   = 0;
  localparam int POS_BELOW  = 0;

  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_ON      = 2'h1;
  localparam logic [1:0] MODE_SAMPLED = 2'h2;
  localparam logic [1:0] MODE_ON_WAIT = 2'h3;

  localparam logic [1:0] TRIG_FROM_ABOVE = 2'h0;
  localparam logic [1:0] TRIG_FROM_BELOW = 2'h1;
  localparam logic [1:0] TRIG_EITHER     = 2'h2;

  localparam logic [1:0] MARGIN_5PCT  = 2'h0;
  localparam logic [1:0] MARGIN_15PCT = 2'h1;
  localparam logic [1:0] MARGIN_25PCT = 2'h2;

  localparam logic [2:0] THR_CODE_ZERO  = 3'h0;
  localparam logic [2:0] THR_CODE_TWO   = 3'h2;
  localparam logic [2:0] THR_CODE_SEVEN = 3'h7;

  localparam logic       RATE_1KHZ   = 1'b0;
  localparam logic       RATE_125HZ  = 1'b1;
  localparam logic [1:0] RST_MARGIN  = 2'h0;
  localparam logic [1:0] RST_TRIG    = 2'h0;
  localparam logic       RST_IE      = 1'b0;
  localparam logic       RST_FLAG    = 1'b0;

  localparam int CLK_HZ   = 40_000_000;
  localparam int FAST_HZ  = 1000;
  localparam int SLOW_HZ  = 125;
  localparam int FAST_DIV = CLK_HZ / FAST_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int DIV_W    = 19;

  localparam int IRQ_N     = 2;
  localparam int IRQ_CROSS = 0;
  localparam int IRQ_READY = 1;

  typedef enum logic [1:0] {BVC_LOAD = 2'b01, BVC_RUN = 2'b10} bvc_state_t;
endpackage

// file: core/bvc_mon_if.sv
// Purpose: carrier between the register bank and the comparator sampler
// Assumes: one clock domain
// Notes:   events are one-cycle pulses
`timescale 1ns/1ps
interface bvc_mon_if;
  logic rate_sel;
  logic mon_on;
  logic mon_sampled;
  logic below_raw;
  logic below;
  logic cross_down;
  logic cross_up;
  modport regs (output rate_sel, mon_on, mon_sampled, below_raw, input below, cross_down, cross_up);
  modport smp  (input rate_sel, mon_on, mon_sampled, below_raw, output below, cross_down, cross_up);
endinterface

// file: core/bvc_sampler.sv
// Purpose: synchronise the comparator, sample it at the chosen rate, find crossings
// Assumes: comparator output is asynchronous to core_clk
// Notes:   while the monitor is off the level is frozen and the events stay low
`timescale 1ns/1ps
module bvc_sampler
  import bvc_pkg::*;
#(
  parameter int FAST_CYC = FAST_DIV,
  parameter int SLOW_CYC = SLOW_DIV
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  bvc_mon_if.smp    mon
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] lim;
  logic             tick;
  logic             sync1;
  logic             sync2;
  logic             below_q;
  logic             take;
  logic             dn_q;
  logic             up_q;

  assign lim  = mon.rate_sel ? DIV_W'(SLOW_CYC - 1) : DIV_W'(FAST_CYC - 1);
  assign tick = (cnt == lim);
  // continuous mode looks every cycle, sampled mode only on the divider tick
  assign take = mon.mon_on & (~mon.mon_sampled | tick);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cnt <= '0;
    else if (!mon.mon_sampled || tick) cnt <= '0;
    else cnt <= cnt + DIV_W'(1);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= mon.below_raw;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      below_q <= 1'b0;
      dn_q    <= 1'b0;
      up_q    <= 1'b0;
    end else begin
      dn_q <= take & sync2 & ~below_q;
      up_q <= take & ~sync2 & below_q;
      if (take) below_q <= sync2;
    end
  end

  assign mon.below      = below_q;
  assign mon.cross_down = dn_q;
  assign mon.cross_up   = up_q;
endmodule // bvc_sampler

// file: testbench/bvc_regs_monitor.sv
// Purpose: port-level assertions for bvc_regs
// Assumes: fuse inputs stay stable after reset release
// Notes:   fuse fields load on edge one, so some checks wait on a counter
`timescale 1ns/1ps
module bvc_regs_chk
  import bvc_pkg::*;
#(
  parameter int FAST_CYC = FAST_DIV,
  parameter int SLOW_CYC = SLOW_DIV
) (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       prot_unlock,
  input wire logic       deep_sleep,
  input wire logic       detector_ready,
  input wire logic [1:0] fuse_active_mode,
  input wire logic       detector_rate,
  input wire logic [2:0] detector_threshold,
  input wire logic [1:0] monitor_margin,
  input wire logic       wake_hold,
  input wire logic       warning_irq_req,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] cyc;
  // edges since reset release, saturating; the load edge must not count as a change
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) cyc <= 2'h0;
    else if (cyc != 2'h3) cyc <= cyc + 2'h1;
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  rate_write_a: assert property (cyc != 2'h0 && reg_wr && reg_addr == OFF_MODE && prot_unlock
    |=> detector_rate == $past(reg_wdata[POS_RATE])) else $error("rate not written");
  rate_locked_a: assert property (cyc != 2'h0 && reg_wr && reg_addr == OFF_MODE && !prot_unlock
    |=> $stable(detector_rate)) else $error("locked write changed rate");
  thr_fixed_a: assert property (cyc == 2'h3 |-> $stable(detector_threshold))
    else $error("threshold changed");
  thr_read_a: assert property (reg_rd && reg_addr == OFF_LEVEL |=> reg_rdata == {5'h00, $past(detector_threshold)})
    else $error("threshold read wrong");
  margin_write_a: assert property (reg_wr && reg_addr == OFF_MARGIN |=> monitor_margin == $past(reg_wdata[1:0]))
    else $error("margin not written");
  req_drop_a: assert property ($fell(warning_irq_req) |-> $past(reg_wr) &&
    ($past(reg_addr) == OFF_FLAGS || $past(reg_addr) == OFF_MONITOR_INTERRUPT_CONTROL)) else $error("request dropped alone");
  flag_read_a: assert property (reg_rd && reg_addr == OFF_FLAGS && warning_irq_req |=> reg_rdata[POS_FLAG])
    else $error("flag read low under request");
  wake_hold_a: assert property (cyc != 2'h0 |-> wake_hold == (fuse_active_mode == MODE_ON_WAIT &&
    !deep_sleep && !detector_ready)) else $error("wake hold does not follow awake mode");
  cover property (reg_wr && reg_addr == OFF_FLAGS && reg_wdata[0] && warning_irq_req);
  cover property ($rose(irq));
  cover property (reg_wr && reg_addr == OFF_MODE && prot_unlock);
endmodule // bvc_regs_chk

bind bvc_regs bvc_regs_chk #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_bvc_regs_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prot_unlock(prot_unlock), .deep_sleep(deep_sleep),
  .detector_ready(detector_ready), .detector_rate(detector_rate), .detector_threshold(detector_threshold),
  .monitor_margin(monitor_margin), .wake_hold(wake_hold), .warning_irq_req(warning_irq_req), .irq(irq),
  .fuse_active_mode(fuse_active_mode));

// file: testbench/tb_top.sv
// Purpose: self-checking bench for bvc_regs
// Assumes: short sample periods for run time
// Notes:   fuses fixed: rate 0, awake 3, sleep 2, threshold 7
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import bvc_pkg::*;
;
  logic       core_clk, arst_n, reg_wr, reg_rd, prot_unlock, deep_sleep, supply_below_async, detector_ready;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       detector_enable, detector_sampled, detector_rate, wake_hold, warning_irq_req, irq;
  logic [2:0] detector_threshold;
  logic [1:0] monitor_margin;
  int         n_errors, cmp_count;
  bvc_regs #(.FAST_CYC(8), .SLOW_CYC(20)) u_bvc_regs (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prot_unlock(prot_unlock), .fuse_sample_rate(1'b0),
    .fuse_active_mode(MODE_ON_WAIT), .fuse_sleep_mode(MODE_SAMPLED), .fuse_threshold(THR_CODE_SEVEN),
    .deep_sleep(deep_sleep), .supply_below_async(supply_below_async), .detector_ready(detector_ready),
    .detector_enable(detector_enable), .detector_sampled(detector_sampled), .detector_rate(detector_rate),
    .detector_threshold(detector_threshold), .monitor_margin(monitor_margin), .wake_hold(wake_hold),
    .warning_irq_req(warning_irq_req), .irq(irq));
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    `CHK(d, e)
  endtask
  // comparator change, then time for sync, sampling tick and flag
  task automatic sup(input logic v);
    @(posedge core_clk) supply_below_async <= v;
    repeat (30) @(posedge core_clk);
  endtask
  task automatic s_reset;
    rc(OFF_MODE, 8'h0e);
    rc(OFF_LEVEL, 8'h07);
    `CHK(detector_threshold, THR_CODE_SEVEN)
    rc(OFF_MARGIN, 8'h00);
    rc(OFF_MONITOR_INTERRUPT_CONTROL, 8'h00);
    rc(OFF_FLAGS, 8'h00);
    rc(OFF_STATUS, 8'h00);
    rc(8'h20, 8'h00);
    `CHK(wake_hold, 1'b1)
  endtask
  task automatic s_prot;
    wr(OFF_MODE, 8'h1f);
    rc(OFF_MODE, 8'h0e);
    wr(OFF_LEVEL, 8'h00);
    rc(OFF_LEVEL, 8'h07);
    @(posedge core_clk) prot_unlock <= 1'b1;
    wr(OFF_MODE, 8'h10);
    rc(OFF_MODE, 8'h1c);
    `CHK(detector_rate, RATE_125HZ)
    @(posedge core_clk) deep_sleep <= 1'b1;
    #1 `CHK(detector_enable, 1'b0)
    wr(OFF_MODE, 8'h01);
    #1 `CHK(detector_enable, 1'b1)
    wr(OFF_MODE, 8'h03);
    #1 `CHK(detector_enable, 1'b0)
    wr(OFF_MODE, 8'h02);
    #1 `CHK(detector_sampled, 1'b1)
    @(posedge core_clk) deep_sleep <= 1'b0;
    #1 `CHK(detector_sampled, 1'b0)
  endtask
  task automatic s_trig;
    // code 3 is reserved and must never set the flag
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MARGIN, 8'(i));
      rc(OFF_MARGIN, 8'(i));
      `CHK(monitor_margin, 2'(i))
      wr(OFF_MONITOR_INTERRUPT_CONTROL, 8'(i << 1));
      wr(OFF_FLAGS, 8'h01);
      sup(1'b1);
      rc(OFF_STATUS, 8'h01);
      rc(OFF_FLAGS, {7'h00, i == 0 || i == 2});
      wr(OFF_FLAGS, 8'h00);
      rc(OFF_FLAGS, {7'h00, i == 0 || i == 2});
      wr(OFF_FLAGS, 8'h01);
      sup(1'b0);
      rc(OFF_STATUS, 8'h00);
      rc(OFF_FLAGS, {7'h00, i == 1 || i == 2});
    end
  endtask
  task automatic s_off;
    wr(OFF_MODE, 8'h00);
    wr(OFF_MONITOR_INTERRUPT_CONTROL, 8'h04);
    wr(OFF_FLAGS, 8'h01);
    @(posedge core_clk) deep_sleep <= 1'b1;
    sup(1'b1);
    rc(OFF_FLAGS, 8'h00);
    rc(OFF_STATUS, 8'h00);
    // slow rate: no tick yet where the fast rate would already have flagged
    wr(OFF_MODE, 8'h12);
    repeat (10) @(posedge core_clk);
    rc(OFF_FLAGS, 8'h00);
    repeat (12) @(posedge core_clk);
    rc(OFF_FLAGS, 8'h01);
    @(posedge core_clk) deep_sleep <= 1'b0;
    sup(1'b0);
  endtask
  task automatic s_irq;
    wr(OFF_MONITOR_INTERRUPT_CONTROL, 8'h00);
    wr(OFF_FLAGS, 8'h01);
    wr(OFF_IRQ_CLR, 8'h03);
    wr(OFF_IRQ_EN, 8'h01);
    rc(OFF_IRQ_STAT, 8'h00);
    wr(OFF_MONITOR_INTERRUPT_CONTROL, 8'h05);
    #1 `CHK(warning_irq_req, 1'b1)
    rc(OFF_FLAGS, 8'h01);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_EN, 8'h00);
    #1 `CHK(irq, 1'b0)
    wr(OFF_IRQ_CLR, 8'h01);
    rc(OFF_IRQ_STAT, 8'h00);
    wr(OFF_FLAGS, 8'h01);
    #1 `CHK(warning_irq_req, 1'b0)
    @(posedge core_clk) detector_ready <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc(OFF_IRQ_STAT, 8'h02);
    `CHK(wake_hold, 1'b0)
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, prot_unlock, deep_sleep, supply_below_async, detector_ready} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    s_reset();
    s_prot();
    s_trig();
    s_off();
    s_irq();
    end_sim();
  end
endmodule // tb_top
